// ---- pkg/sas_pkg.sv ----
// Shared constants and types for the bus arbitration and selection ends
package sas_pkg;
   localparam int SAS_CLK_MHZ = 250;
   // Spin-up ready window, seconds
   localparam int SAS_READY_MIN_S = 13;
   localparam int SAS_READY_MAX_S = 15;
   localparam longint SAS_READY_MIN_CYC = longint'(SAS_READY_MIN_S) * 64'd1000000 * SAS_CLK_MHZ;
   localparam longint SAS_READY_MAX_CYC = longint'(SAS_READY_MAX_S) * 64'd1000000 * SAS_CLK_MHZ;
   // Arbitration delay, nanoseconds, rounded up
   localparam int SAS_ARB_DELAY_NS = 2200;
   localparam int SAS_ARB_CYC = (SAS_ARB_DELAY_NS * SAS_CLK_MHZ + 999) / 1000;
   // Bus free delay, nanoseconds, rounded up
   localparam int SAS_FREE_DELAY_NS = 800;
   localparam int SAS_FREE_CYC = (SAS_FREE_DELAY_NS * SAS_CLK_MHZ + 999) / 1000;
   localparam int SAS_MAX_SEL_IDS = 2;
   localparam logic [7:0] SAS_RST_DATA = 8'h00;
   // Information phase codes {msg, cd, io}
   localparam logic [2:0] SAS_PH_DATA_OUT = 3'h0;
   localparam logic [2:0] SAS_PH_DATA_IN = 3'h1;
   localparam logic [2:0] SAS_PH_COMMAND = 3'h2;
   localparam logic [2:0] SAS_PH_STATUS = 3'h3;
   localparam logic [2:0] SAS_PH_MSG_OUT = 3'h6;
   localparam logic [2:0] SAS_PH_MSG_IN = 3'h7;
   // Tracked bus phase, one-hot
   typedef enum logic [7:0] {
      SAS_BP_FREE = 8'h01,
      SAS_BP_ARB = 8'h02,
      SAS_BP_SEL = 8'h04,
      SAS_BP_RESEL = 8'h08,
      SAS_BP_COMMAND = 8'h10,
      SAS_BP_DATA = 8'h20,
      SAS_BP_STATUS = 8'h40,
      SAS_BP_MESSAGE = 8'h80
   } sas_phase_t;

   // Odd parity bit for a byte, bit 7 is MSB
   function automatic logic sas_odd_par(input logic [7:0] b);
      return ~(^b);
   endfunction

   // Count of asserted ID bits
   function automatic logic [3:0] sas_ones(input logic [7:0] b);
      logic [3:0] n;
      n = 4'h0;
      for (int i = 0; i < 8; i++)
      begin
         n = n + {3'h0, b[i]};
      end
      return n;
   endfunction

   // True when any bit above position id is set
   function automatic logic sas_higher(input logic [7:0] b, input logic [2:0] id);
      logic [7:0] m;
      m = 8'hFF << id;
      m = m << 1;
      return |(b & m);
   endfunction
endpackage

// ---- pkg/sas_bus_if.sv ----
// Bus wires between target and initiator, levels as asserted-high
`timescale 1ns/1ps
interface sas_bus_if;
   logic [7:0] db_t_o;
   logic [7:0] db_t_oe;
   logic dbp_t_o;
   logic dbp_t_oe;
   logic bsy_t_o;
   logic sel_t_o;
   logic msg_t_o;
   logic cd_t_o;
   logic io_t_o;
   logic req_t_o;
   logic [7:0] db_i_o;
   logic [7:0] db_i_oe;
   logic dbp_i_o;
   logic dbp_i_oe;
   logic bsy_i_o;
   logic sel_i_o;
   logic atn_i_o;
   logic ack_i_o;
   logic rst_i_o;
   // Wired-or of the asserted levels
   wire [7:0] db = (db_t_o & db_t_oe) | (db_i_o & db_i_oe);
   wire dbp = (dbp_t_o & dbp_t_oe) | (dbp_i_o & dbp_i_oe);
   wire bsy = bsy_t_o | bsy_i_o;
   wire sel = sel_t_o | sel_i_o;
   modport target (
      output db_t_o, db_t_oe, dbp_t_o, dbp_t_oe, bsy_t_o, sel_t_o,
      output msg_t_o, cd_t_o, io_t_o, req_t_o,
      input db, dbp, bsy, sel, atn_i_o, ack_i_o, rst_i_o
   );
   modport initiator (
      output db_i_o, db_i_oe, dbp_i_o, dbp_i_oe, bsy_i_o, sel_i_o,
      output atn_i_o, ack_i_o, rst_i_o,
      input db, dbp, bsy, sel, msg_t_o, cd_t_o, io_t_o, req_t_o
   );
endinterface

// ---- hw/sas_target.sv ----
// Target end: readiness, phase tracking, bus free, selection response; it never arbitrates
`timescale 1ns/1ps
module sas_target
   import sas_pkg::*;
#(
   parameter logic [2:0] OWN_ID = 3'h0,
   parameter longint READY_CYC = SAS_READY_MIN_CYC
)
(
   input wire logic clk, // Clock, 250 MHz
   input wire logic rst_n, // Asynchronous reset, active low
   sas_bus_if.target bus, // Bus wires
   input wire logic par_chk_en, // Parity check on selection
   input wire logic start_stop, // Start/stop command pulse
   input wire logic done_msg, // Command complete or disconnect finished, pulse
   input wire logic [2:0] info_phase, // Requested information phase code
   input wire logic info_go, // Enter information phase, pulse
   output logic ready, // Drive ready
   output logic recal, // Recalibration running
   output logic selected, // Selected and holding BSY
   output logic [7:0] phase // Tracked bus phase, one-hot
);
   // Elaboration check: the count must be at least 1 and no more than the top of the spin-up window
   if (READY_CYC < 1 || READY_CYC > SAS_READY_MAX_CYC)
   begin : g_bad_ready
      $error("READY_CYC outside ready window");
   end

   // Registers; every top output below is a plain copy of one of these
   logic [39:0] rdy_cnt_q;
   logic recal_q;
   logic ready_q;
   logic bsy_q;
   logic req_q;
   logic [2:0] ph_code_q;
   sas_phase_t phase_q;
   sas_phase_t phase_d;

   // Selection decode; I/O is negated during selection, reselection has it set
   wire own_bit = bus.db[OWN_ID];
   wire ids_ok = sas_ones(bus.db) <= 4'(SAS_MAX_SEL_IDS);
   wire par_ok = !par_chk_en || (bus.dbp == sas_odd_par(bus.db));
   // Not ready means still spinning up: selection is ignored and the initiator keeps waiting for BSY
   wire sel_valid = bus.sel && !bus.bsy && own_bit && ids_ok && par_ok && ready_q;
   // Bus reset acts as a synchronous return to idle
   wire bus_rst = bus.rst_i_o;

   // Line conditions for each phase, from SEL, BSY, MSG, C/D, I/O, REQ, ACK only
   wire ln_free = !bus.bsy && !bus.sel;
   wire ln_arb = bus.bsy && bus.sel;
   wire ln_resel = bus.sel && bus.io_t_o;
   wire ln_sel = bus.sel && !bus.io_t_o;
   // Information phases count only once REQ or ACK of the first byte shows
   wire ln_xfer = bus.req_t_o || bus.ack_i_o;
   wire ln_data = ln_xfer && !bus.msg_t_o && !bus.cd_t_o;
   wire ln_cmd = ln_xfer && !bus.msg_t_o && bus.cd_t_o && !bus.io_t_o;
   wire ln_stat = ln_xfer && !bus.msg_t_o && bus.cd_t_o && bus.io_t_o;
   wire ln_msg = ln_xfer && bus.msg_t_o && bus.cd_t_o;

   // Priority follows the bus: free, arbitration, selection, then transfer
   always_comb
   begin
      phase_d = phase_q;
      if (ln_free)
         phase_d = SAS_BP_FREE;
      else if (ln_arb)
         phase_d = SAS_BP_ARB;
      else if (ln_resel)
         phase_d = SAS_BP_RESEL;
      else if (ln_sel)
         phase_d = SAS_BP_SEL;
      else if (ln_data)
         phase_d = SAS_BP_DATA;
      else if (ln_cmd)
         phase_d = SAS_BP_COMMAND;
      else if (ln_stat)
         phase_d = SAS_BP_STATUS;
      else if (ln_msg)
         phase_d = SAS_BP_MESSAGE;
   end

   // Power-up and start/stop recalibration with spin-up timer
   // A start/stop during spin-up restarts the count, so the wait grows
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdy_cnt_q <= 40'h0;
         recal_q <= 1'b1;
         ready_q <= 1'b0;
      end
      else if (start_stop)
      begin
         rdy_cnt_q <= 40'h0;
         recal_q <= 1'b1;
         ready_q <= 1'b0;
      end
      else if (recal_q)
      begin
         rdy_cnt_q <= rdy_cnt_q + 40'h1;
         if (rdy_cnt_q >= 40'(READY_CYC - 1))
         begin
            recal_q <= 1'b0;
            ready_q <= 1'b1;
         end
      end
   end

   // Only the six defined phase codes reach the lines; MSG without C/D is reserved
   function automatic logic code_legal(input logic [2:0] c);
      return (c == SAS_PH_DATA_OUT) || (c == SAS_PH_DATA_IN) ||
         (c == SAS_PH_COMMAND) || (c == SAS_PH_STATUS) ||
         (c == SAS_PH_MSG_OUT) || (c == SAS_PH_MSG_IN);
   endfunction

   // A new phase waits until the previous byte's handshake is over
   wire info_ok = info_go && bsy_q && !bus.sel && !req_q && code_legal(info_phase);

   // BSY response and release; a selection wins over a release in one cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         bsy_q <= 1'b0;
      else if (bus_rst)
         bsy_q <= 1'b0;
      else if (sel_valid)
         bsy_q <= 1'b1;
      else if (done_msg)
         bsy_q <= 1'b0;
   end

   // Phase code and REQ; reset or release drops the handshake with BSY
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         req_q <= 1'b0;
         ph_code_q <= SAS_PH_DATA_OUT;
      end
      else if (bus_rst || done_msg)
      begin
         req_q <= 1'b0;
         ph_code_q <= SAS_PH_DATA_OUT;
      end
      else if (info_ok)
      begin
         ph_code_q <= info_phase;
         req_q <= 1'b1;
      end
      else if (req_q && bus.ack_i_o)
         req_q <= 1'b0;
   end

   // One-hot phase register: only decoded values loaded
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         phase_q <= SAS_BP_FREE;
      else
         phase_q <= phase_d;
   end

   // Bus outputs; I/O held low until an information phase starts
   // Data lines stay released: this end never arbitrates or reselects
   assign bus.db_t_o = SAS_RST_DATA;
   assign bus.db_t_oe = 8'h00;
   assign bus.dbp_t_o = 1'b0;
   assign bus.dbp_t_oe = 1'b0;
   assign bus.sel_t_o = 1'b0;
   assign bus.bsy_t_o = bsy_q;
   assign bus.req_t_o = req_q;
   assign bus.msg_t_o = bsy_q && ph_code_q[2];
   assign bus.cd_t_o = bsy_q && ph_code_q[1];
   assign bus.io_t_o = bsy_q && !bus.sel && ph_code_q[0];

   // Top outputs, straight from flops
   assign ready = ready_q;
   assign recal = recal_q;
   assign selected = bsy_q;
   assign phase = phase_q;
endmodule

// ---- hw/sas_initiator.sv ----
// Initiator end: arbitration and selection of one target
`timescale 1ns/1ps
module sas_initiator
   import sas_pkg::*;
#(
   parameter logic [2:0] OWN_ID = 3'h7,
   parameter bit USE_ARB = 1'b1
)
(
   input wire logic clk, // Clock, 250 MHz
   input wire logic rst_n, // Asynchronous reset, active low
   sas_bus_if.initiator bus, // Bus wires
   input wire logic go, // Start selection, pulse
   input wire logic [2:0] tgt_id, // Target to select
   input wire logic want_atn, // Disconnect support, raise ATN at selection; ignored when USE_ARB is 0
   input wire logic bus_reset, // Drive bus reset level
   input wire logic ack_in, // ACK level for transfers
   output logic busy, // Sequence running
   output logic lost, // Lost arbitration, pulse
   output logic done // Target answered, pulse
);
   typedef enum logic [5:0] {
      SAS_I_IDLE = 6'h01,
      SAS_I_WFREE = 6'h02,
      SAS_I_ARB = 6'h04,
      SAS_I_SEL = 6'h08,
      SAS_I_WBSY = 6'h10,
      SAS_I_REL = 6'h20
   } sas_init_t;

   sas_init_t st_q;
   logic [11:0] cnt_q;
   logic [7:0] db_q;
   logic dboe_q;
   logic bsy_q;
   logic sel_q;
   logic atn_q;
   logic lost_q;
   logic done_q;
   logic [2:0] tid_q;

   wire free_now = !bus.bsy && !bus.sel;
   wire [7:0] own_bit = 8'h01 << OWN_ID;
   wire [7:0] tgt_bit = 8'h01 << tid_q;
   wire higher = sas_higher(bus.db, OWN_ID);

   // Arbitration, selection and release sequence
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= SAS_I_IDLE;
         cnt_q <= 12'h0;
         db_q <= 8'h00;
         dboe_q <= 1'b0;
         bsy_q <= 1'b0;
         sel_q <= 1'b0;
         atn_q <= 1'b0;
         lost_q <= 1'b0;
         done_q <= 1'b0;
         tid_q <= 3'h0;
      end
      else
      begin
         lost_q <= 1'b0;
         done_q <= 1'b0;
         cnt_q <= (free_now || st_q != SAS_I_WFREE) ? cnt_q + 12'h1 : 12'h0;
         case (st_q)
            SAS_I_IDLE:
               if (go)
               begin
                  tid_q <= tgt_id;
                  cnt_q <= 12'h0;
                  st_q <= SAS_I_WFREE;
               end
            SAS_I_WFREE:
               if (free_now && cnt_q >= 12'(SAS_FREE_CYC))
               begin
                  cnt_q <= 12'h0;
                  dboe_q <= 1'b1;
                  if (USE_ARB)
                  begin
                     db_q <= own_bit;
                     bsy_q <= 1'b1;
                     st_q <= SAS_I_ARB;
                  end
                  else
                  begin
                     db_q <= tgt_bit;
                     sel_q <= 1'b1;
                     st_q <= SAS_I_WBSY;
                  end
               end
            SAS_I_ARB:
               if (cnt_q >= 12'(SAS_ARB_CYC))
               begin
                  cnt_q <= 12'h0;
                  if (higher)
                  begin
                     bsy_q <= 1'b0;
                     dboe_q <= 1'b0;
                     lost_q <= 1'b1;
                     st_q <= SAS_I_WFREE;
                  end
                  else
                  begin
                     sel_q <= 1'b1;
                     db_q <= own_bit | tgt_bit;
                     atn_q <= want_atn;
                     st_q <= SAS_I_SEL;
                  end
               end
            SAS_I_SEL:
            begin
               bsy_q <= 1'b0;
               st_q <= SAS_I_WBSY;
            end
            SAS_I_WBSY:
               if (bus.bsy && !bsy_q)
               begin
                  sel_q <= 1'b0;
                  st_q <= SAS_I_REL;
               end
            SAS_I_REL:
            begin
               dboe_q <= 1'b0;
               done_q <= 1'b1;
               st_q <= SAS_I_IDLE;
            end
            default: st_q <= SAS_I_IDLE;
         endcase
      end
   end

   // Parity follows the driven byte
   assign bus.db_i_o = db_q;
   assign bus.db_i_oe = {8{dboe_q}};
   assign bus.dbp_i_o = sas_odd_par(db_q);
   assign bus.dbp_i_oe = dboe_q;
   assign bus.bsy_i_o = bsy_q;
   assign bus.sel_i_o = sel_q;
   assign bus.atn_i_o = atn_q;
   assign bus.ack_i_o = ack_in;
   assign bus.rst_i_o = bus_reset;
   assign busy = st_q != SAS_I_IDLE;
   assign lost = lost_q;
   assign done = done_q;
endmodule

// ---- sim/sas_bus_monitor.sv ----
// Bus checks between initiator and target ends
`timescale 1ns/1ps
module sas_bus_monitor
#(
   parameter logic [2:0] TGT_ID = 3'h0
)
(
   input wire logic clk, // Clock
   input wire logic rst_n, // Reset, active low
   input wire [7:0] db, // Data lines
   input wire dbp, // Parity line
   input wire bsy, // Resolved BSY
   input wire sel, // Resolved SEL
   input wire logic bsy_t_o, // Target BSY
   input wire logic io_t_o, // Target I/O
   input wire logic msg_t_o, // Target MSG
   input wire logic cd_t_o, // Target C/D
   input wire logic req_t_o, // Target REQ
   input wire logic bsy_i_o, // Initiator BSY
   input wire logic sel_i_o, // Initiator SEL
   input wire logic atn_i_o, // Initiator ATN
   input wire logic ack_i_o, // Initiator ACK
   input wire logic rst_i_o // Initiator RST
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Target side of selection
   a_sel_io_low: assert property (sel |-> !io_t_o) else $error("io high in selection");
   a_sel_answer_valid: assert property ($rose(bsy_t_o) |->
      $past(sel && !bsy && db[TGT_ID] && $countones(db) <= 2)) else $error("bad answer");
   a_sel_release: assert property ($rose(bsy_t_o) |-> ##[1:2] !sel) else $error("sel held");
   // Initiator arbitration; eight free cycles is a floor, not the full delay
   a_arb_entry: assert property ($rose(bsy_i_o) |->
      $past(!bsy && !sel, 8) ##[0:1] db[7]) else $error("arb entry");
   a_arb_win: assert property ($rose(sel_i_o) |-> bsy_i_o && $past(bsy_i_o, 8) && db[7])
      else $error("arb win");
   a_sel_ids_held: assert property ($rose(sel_i_o) |=>
      !bsy_i_o && sel_i_o && db == (8'h80 | (8'h01 << TGT_ID))) else $error("sel ids");
   a_atn_first: assert property ($fell(bsy_i_o) && sel_i_o |-> $past(atn_i_o))
      else $error("atn late");
   a_parity_odd: assert property (sel && !bsy |-> ^{db, dbp}) else $error("parity even");
   // Target release and information phases
   a_rst_free: assert property (rst_i_o |-> ##[1:2] !bsy_t_o) else $error("bsy held");
   a_phase_code: assert property (req_t_o |-> !(msg_t_o && !cd_t_o) && bsy_t_o && !sel)
      else $error("bad phase code");
   a_req_hold: assert property ($fell(req_t_o) |-> $past(ack_i_o)) else $error("req dropped");
endmodule

// ---- sim/tb_scsi_arbitration_selection.sv ----
// Bench joining both ends, plus a second target driven by hand
`timescale 1ns/1ps
module tb_scsi_arbitration_selection;
   import sas_pkg::*;
   localparam logic [2:0] CODES [6] = '{SAS_PH_DATA_OUT, SAS_PH_DATA_IN, SAS_PH_COMMAND,
      SAS_PH_STATUS, SAS_PH_MSG_OUT, SAS_PH_MSG_IN};
   localparam logic [7:0] PHS [6] = '{SAS_BP_DATA, SAS_BP_DATA, SAS_BP_COMMAND,
      SAS_BP_STATUS, SAS_BP_MESSAGE, SAS_BP_MESSAGE};
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic par_en = 1'b1;
   logic start_stop = 1'b0;
   logic done_msg = 1'b0;
   logic [2:0] info_phase = 3'h0;
   logic info_go = 1'b0;
   logic go = 1'b0;
   logic bus_reset = 1'b0;
   logic ack_in = 1'b0;
   logic go3 = 1'b0;
   logic sel3, done3;
   logic ready, recal, selected, sel2, busy, lost, done;
   logic [7:0] phase;
   int errors = 0;
   int checked = 0;
   int n;
   sas_bus_if bus_i();
   sas_bus_if bus2_i();
   sas_bus_if bus3_i();

   always #2 clk = ~clk;

   // Main pair, ready count shortened to keep the run small
   sas_target #(.READY_CYC(100)) sas_target_i (.clk(clk), .rst_n(rst_n), .bus(bus_i),
      .par_chk_en(par_en), .start_stop(start_stop), .done_msg(done_msg),
      .info_phase(info_phase), .info_go(info_go), .ready(ready), .recal(recal),
      .selected(selected), .phase(phase));
   sas_initiator sas_initiator_i (.clk(clk), .rst_n(rst_n), .bus(bus_i), .go(go),
      .tgt_id(3'h0), .want_atn(1'b1), .bus_reset(bus_reset), .ack_in(ack_in),
      .busy(busy), .lost(lost), .done(done));
   // Second target faces a bench that breaks selection on purpose
   sas_target #(.READY_CYC(100)) sas_target_b_i (.clk(clk), .rst_n(rst_n), .bus(bus2_i),
      .par_chk_en(par_en), .start_stop(start_stop), .done_msg(done_msg),
      .info_phase(info_phase), .info_go(info_go), .ready(), .recal(), .selected(sel2),
      .phase());
   // Third pair: initiator without arbitration
   sas_target #(.READY_CYC(100)) sas_target_c_i (.clk(clk), .rst_n(rst_n), .bus(bus3_i),
      .par_chk_en(par_en), .start_stop(start_stop), .done_msg(done_msg),
      .info_phase(info_phase), .info_go(info_go), .ready(), .recal(), .selected(sel3),
      .phase());
   sas_initiator #(.USE_ARB(1'b0)) sas_initiator_c_i (.clk(clk), .rst_n(rst_n),
      .bus(bus3_i), .go(go3), .tgt_id(3'h0), .want_atn(1'b0), .bus_reset(bus_reset),
      .ack_in(1'b0), .busy(), .lost(), .done(done3));
   sas_bus_monitor sas_bus_monitor_i (.clk(clk), .rst_n(rst_n), .db(bus_i.db),
      .dbp(bus_i.dbp), .bsy(bus_i.bsy), .sel(bus_i.sel), .bsy_t_o(bus_i.bsy_t_o),
      .io_t_o(bus_i.io_t_o), .msg_t_o(bus_i.msg_t_o), .cd_t_o(bus_i.cd_t_o),
      .req_t_o(bus_i.req_t_o), .bsy_i_o(bus_i.bsy_i_o), .sel_i_o(bus_i.sel_i_o),
      .atn_i_o(bus_i.atn_i_o), .ack_i_o(bus_i.ack_i_o), .rst_i_o(bus_i.rst_i_o));

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_sim();
      $display("checked=%0d errors=%0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // Host side of the second bus; released lines rest negated by termination
   task automatic drv2(input logic [7:0] b, input logic p, input logic s, input logic r);
      bus2_i.db_i_o <= b;
      bus2_i.db_i_oe <= 8'hFF;
      bus2_i.dbp_i_o <= p;
      bus2_i.dbp_i_oe <= 1'b1;
      bus2_i.bsy_i_o <= 1'b0;
      bus2_i.sel_i_o <= s;
      bus2_i.atn_i_o <= 1'b0;
      bus2_i.ack_i_o <= 1'b0;
      bus2_i.rst_i_o <= r;
   endtask

   task automatic wait_rdy();
      repeat (88) @(posedge clk);
      chk(recal, 1'b1);
      chk(ready, 1'b0);
      for (n = 0; n < 40 && ready !== 1'b1; n++) @(posedge clk);
      chk(ready, 1'b1);
   endtask

   task automatic t_power();
      chk(phase, SAS_BP_FREE);
      wait_rdy();
      start_stop <= 1'b1;
      @(posedge clk);
      start_stop <= 1'b0;
      wait_rdy();
   endtask

   task automatic t_select();
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      for (n = 0; n < 1500 && done !== 1'b1; n++) @(posedge clk);
      chk(done, 1'b1);
      chk(lost, 1'b0);
      chk(bus_i.bsy_t_o, 1'b1);
      chk(bus_i.sel, 1'b0);
      chk(selected, 1'b1);
   endtask

   // Every information phase code, one handshake each
   task automatic t_info();
      for (int k = 0; k < 6; k++)
      begin
         info_phase <= CODES[k];
         info_go <= 1'b1;
         @(posedge clk);
         info_go <= 1'b0;
         for (n = 0; n < 20 && bus_i.req_t_o !== 1'b1; n++) @(posedge clk);
         @(posedge clk);
         chk({bus_i.msg_t_o, bus_i.cd_t_o, bus_i.io_t_o}, CODES[k]);
         chk(phase, PHS[k]);
         ack_in <= 1'b1;
         for (n = 0; n < 20 && bus_i.req_t_o !== 1'b0; n++) @(posedge clk);
         ack_in <= 1'b0;
         chk(bus_i.req_t_o, 1'b0);
         repeat (3) @(posedge clk);
      end
      // A reserved code must neither raise REQ nor reach the lines
      info_phase <= 3'h4;
      info_go <= 1'b1;
      @(posedge clk);
      info_go <= 1'b0;
      repeat (3) @(posedge clk);
      chk(bus_i.req_t_o, 1'b0);
      chk({bus_i.msg_t_o, bus_i.cd_t_o, bus_i.io_t_o}, SAS_PH_MSG_IN);
   endtask

   // Selection straight from bus free, only the target's ID on the lines
   task automatic t_noarb();
      go3 <= 1'b1;
      @(posedge clk);
      go3 <= 1'b0;
      for (n = 0; n < 400 && bus3_i.sel_i_o !== 1'b1; n++) @(posedge clk);
      chk(bus3_i.bsy, 1'b0);
      chk(bus3_i.db, 8'h01);
      for (n = 0; n < 40 && done3 !== 1'b1; n++) @(posedge clk);
      chk(done3, 1'b1);
      chk(sel3, 1'b1);
      chk(bus3_i.sel, 1'b0);
   endtask

   task automatic t_release(input logic use_rst);
      if (use_rst)
         bus_reset <= 1'b1;
      else
         done_msg <= 1'b1;
      @(posedge clk);
      done_msg <= 1'b0;
      repeat (3) @(posedge clk);
      bus_reset <= 1'b0;
      chk(bus_i.bsy, 1'b0);
      chk(selected, 1'b0);
      chk(phase, SAS_BP_FREE);
      repeat (2) @(posedge clk);
   endtask

   task automatic try2(input logic [7:0] b, input logic p, input logic exp);
      drv2(b, p, 1'b1, 1'b0);
      repeat (6) @(posedge clk);
      chk(bus2_i.bsy, exp);
   endtask

   // Refused selections, then one accepted with parity checking off
   task automatic t_bad();
      try2(8'h83, ~^8'h83, 1'b0);
      try2(8'h82, ~^8'h82, 1'b0);
      try2(8'h81, ^8'h81, 1'b0);
      par_en <= 1'b0;
      try2(8'h81, ^8'h81, 1'b1);
      chk(sel2, 1'b1);
      drv2(8'h00, 1'b0, 1'b0, 1'b1);
      repeat (3) @(posedge clk);
      chk(bus2_i.bsy, 1'b0);
   endtask

   initial
   begin
      drv2(8'h00, 1'b0, 1'b0, 1'b0);
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      t_power();
      t_select();
      t_info();
      t_release(1'b0);
      t_select();
      t_release(1'b1);
      t_noarb();
      t_bad();
      end_sim();
   end

   // Hang guard: the run needs about 2000 cycles
   initial
   begin
      #40000;
      errors++;
      end_sim();
   end
endmodule
